// *** rtl/acl_table_indirect_access.sv ***
// Chosen here: the placing of the registers and the plain strobed port.
`include "acl_table_consts.svh"

module acl_table_indirect_access (
    // Clock and reset
    input  wire logic                    clk_sys_i,
    input  wire logic                    reset_i,
    // Register port
    input  wire logic [4:0]              addr_i,
    input  wire logic [7:0]              wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output logic      [7:0]              rdata_o,
    // Decoded fields of the staged entry
    output logic      [2:0]              remark_priority_o,
    output logic      [5:0]              forward_port_mask_o,
    output acl_table_pkg::rule_mode_t    rule_mode_o,
    output logic                         match_on_equal_o,
    output logic                         transfer_busy_o
);
    import acl_table_pkg::*;

    // ==========================================================
    // Table store and state
    logic [15:0][7:0] table_mem [16];
    acl_state_t       st_r;
    acl_state_t       st_nxt;

    // Byte-enable bit i addresses staging byte 15-i
    function automatic logic [15:0] byte_select_map(input logic [7:0] high, input logic [7:0] low);
        logic [15:0] m;
        m = '0;
        for (int i = 0; i < 8; i++) begin
            m[7 - i]  = high[i]; // see RULE3
            m[15 - i] = low[i];  // see RULE4
        end
        return m;
    endfunction

    function automatic logic [7:0] reg_read(input acl_state_t s, input logic [4:0] a);
        logic [7:0] v;
        logic [15:0] sel_raw;
        v = 8'h00;
        sel_raw = '0;
        for (int i = 0; i < 8; i++) begin
            sel_raw[8 + i] = s.select[7 - i];
            sel_raw[i]     = s.select[15 - i];
        end
        if (a <= `ACL_OFS_STAGE_LAST) begin
            v = s.stage[a[3:0]];
        end else if (a == `ACL_OFS_SEL_HIGH) begin
            v = sel_raw[15:8];
        end else if (a == `ACL_OFS_SEL_LOW) begin
            v = sel_raw[7:0];
        end else if (a == `ACL_OFS_CONTROL) begin
            v = {1'b0, s.wr_done, s.rd_done, s.direction, s.index}; // see RULE7 // see RULE8
        end
        return v;
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        if (rd_i) begin
            st_nxt.rdata = reg_read(st_r, addr_i);
        end
        if (wr_i) begin
            if (addr_i <= `ACL_OFS_STAGE_LAST) begin
                st_nxt.stage[addr_i[3:0]] = wdata_i;
            end else if (addr_i == `ACL_OFS_SEL_HIGH) begin
                st_nxt.select = byte_select_map(wdata_i, 8'h00) | (st_r.select & 16'hff00);
            end else if (addr_i == `ACL_OFS_SEL_LOW) begin
                // Low byte-enable write launches the transfer
                st_nxt.select = byte_select_map(8'h00, wdata_i) | (st_r.select & 16'h00ff);
                st_nxt.walk   = 4'h0;
                st_nxt.busy   = 1'b1;
                if (st_r.direction) begin // see RULE5
                    st_nxt.state   = XFER_WRITE;
                    st_nxt.wr_done = 1'b0; // see RULE13
                end else begin
                    st_nxt.state   = XFER_READ;
                    st_nxt.rd_done = 1'b0; // see RULE13
                end
            end else if (addr_i == `ACL_OFS_CONTROL) begin
                st_nxt.direction = wdata_i[`ACL_CTL_DIR_BIT];
                st_nxt.index     = wdata_i[3:0];
            end
        end
        // Walk the sixteen byte lanes, one per cycle; a read fills each selected staging byte as the walk reaches it
        case (st_r.state)
            XFER_IDLE: begin
            end
            XFER_READ: begin
                if (st_r.select[st_r.walk]) begin // see RULE6 // see RULE12
                    st_nxt.stage[st_r.walk] = table_mem[st_r.index][st_r.walk];
                end
                st_nxt.walk = st_r.walk + 4'h1;
                if (st_r.walk == `ACL_LAST_ENTRY) begin
                    st_nxt.state   = XFER_IDLE;
                    st_nxt.rd_done = 1'b1; // see RULE13 // see RULE8
                    st_nxt.busy    = 1'b0;
                end
            end
            XFER_WRITE: begin
                st_nxt.walk = st_r.walk + 4'h1;
                if (st_r.walk == `ACL_LAST_ENTRY) begin
                    st_nxt.state   = XFER_IDLE;
                    st_nxt.wr_done = 1'b1; // see RULE13 // see RULE7
                    st_nxt.busy    = 1'b0;
                end
            end
            default: begin
                st_nxt.state = XFER_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_r       <= '0;
            st_r.wr_done <= 1'b1;
            st_r.rd_done <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Table store has no reset: it is RAM, contents undefined at power-up
    always_ff @(posedge clk_sys_i) begin
        if (st_r.state == XFER_WRITE && st_r.select[st_r.walk]) begin // see RULE6 // see RULE12
            table_mem[st_r.index][st_r.walk] <= st_r.stage[st_r.walk];
        end
    end

    // ==========================================================
    // Outputs, all registered
    logic [2:0] remark_r;
    logic [5:0] fwd_r;
    logic [1:0] mode_r;
    logic       cmp_r;
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            remark_r <= 3'h0;
            fwd_r    <= 6'h00;
            mode_r   <= 2'h0;
            cmp_r    <= 1'b0;
        end else begin
            remark_r <= {st_nxt.stage[`ACL_BYTE_REMARK_MSB][1:0],
                         st_nxt.stage[`ACL_BYTE_REMARK_LSB][`ACL_REMARK_LSB_BIT]}; // see RULE1
            fwd_r    <= st_nxt.stage[`ACL_BYTE_FWD_MASK][5:0]; // see RULE2
            mode_r   <= st_nxt.stage[`ACL_BYTE_MODE_CMP][5:4]; // see RULE10
            cmp_r    <= st_nxt.stage[`ACL_BYTE_MODE_CMP][0];   // see RULE11
        end
    end

    assign rdata_o             = st_r.rdata;
    assign remark_priority_o   = remark_r;
    assign forward_port_mask_o = fwd_r;
    assign rule_mode_o         = rule_mode_t'(mode_r);
    assign match_on_equal_o    = cmp_r;
    assign transfer_busy_o     = st_r.busy;
endmodule

// *** rtl/acl_table_consts.svh ***
// Contract
// RULE1 - Remark priority LSB sits in bit 7 of the byte after the two MSBs
// RULE2 - Six-bit forward mask, bit 0 is port 1; set bit forwards there
// RULE3 - High byte-enable bit 0 picks staging byte 7, bit 7 picks byte 0
// RULE4 - Low byte-enable bit 0 picks byte 15, bit 7 picks byte 8
// RULE5 - Writing low byte-enable starts transfer at 4-bit index; direction 1 writes, 0 reads
// RULE6 - Only staging bytes with byte-enable set move during a transfer
// RULE7 - Write-complete flag, control bit 6, resets to one, zero while writing
// RULE8 - Read-complete flag, control bit 5, resets to one, zero while reading
// RULE9 - Host polls read-complete until one before reading result bytes
// RULE10 - Rule mode 00 none, 01 layer 2, 10 layer 3, 11 layer 4
// RULE11 - Compare-sense one matches on equal, zero matches on differ
// RULE12 - Unselected table bytes and unselected staging bytes stay unchanged
// RULE13 - Completion flag clears on start cycle, sets when table access ends
`ifndef ACL_TABLE_CONSTS_SVH
`define ACL_TABLE_CONSTS_SVH

// ==========================================================
// Register offsets
`define ACL_OFS_STAGE_FIRST   5'h00
`define ACL_OFS_STAGE_LAST    5'h0f
`define ACL_OFS_SEL_HIGH      5'h10
`define ACL_OFS_SEL_LOW       5'h11
`define ACL_OFS_CONTROL       5'h12

// ==========================================================
// Field positions
`define ACL_CTL_WR_DONE_BIT   6
`define ACL_CTL_RD_DONE_BIT   5
`define ACL_CTL_DIR_BIT       4
`define ACL_REMARK_LSB_BIT    7
`define ACL_BYTE_REMARK_MSB   4'ha
`define ACL_BYTE_REMARK_LSB   4'hb
`define ACL_BYTE_MODE_CMP     4'h1
`define ACL_BYTE_FWD_MASK     4'hd

// ==========================================================
// Reset values and timing
`define ACL_STAGE_RESET       8'h00
`define ACL_LAST_ENTRY        4'hf
`define ACL_ENTRY_BYTES       16

`endif

// *** rtl/acl_table_pkg.sv ***
package acl_table_pkg;
    typedef enum logic [1:0] {
        XFER_IDLE  = 2'b00,
        XFER_READ  = 2'b01,
        XFER_WRITE = 2'b10
    } xfer_state_t;

    typedef enum logic [1:0] {
        MODE_NONE   = 2'b00,
        MODE_LAYER2 = 2'b01,
        MODE_LAYER3 = 2'b10,
        MODE_LAYER4 = 2'b11
    } rule_mode_t;

    typedef struct packed {
        xfer_state_t       state;
        logic [3:0]        index;
        logic              direction;
        logic              wr_done;
        logic              rd_done;
        logic [3:0]        walk;
        logic [15:0]       select;
        logic [15:0][7:0]  stage;
        logic [7:0]        rdata;
        logic              busy;
    } acl_state_t;
endpackage

// *** testbench/acl_table_chk.sv ***
module acl_table_chk (
    // Clock and reset
    input wire logic                      clk_sys_i,
    input wire logic                      reset_i,
    // Register port
    input wire logic [4:0]                addr_i,
    input wire logic [7:0]                wdata_i,
    input wire logic                      wr_i,
    input wire logic                      rd_i,
    input wire logic [7:0]                rdata_o,
    // Decoded fields
    input wire logic [2:0]                remark_priority_o,
    input wire logic [5:0]                forward_port_mask_o,
    input wire acl_table_pkg::rule_mode_t rule_mode_o,
    input wire logic                      match_on_equal_o,
    input wire logic                      transfer_busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import acl_table_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    logic dir_r;
    logic ctl_rd;
    assign ctl_rd = rd_i && addr_i == 5'h12;
    // Direction of the running walk; host never rewrites control while busy
    always_ff @(posedge clk_sys_i) if (wr_i && addr_i == 5'h12) dir_r <= wdata_i[4];
    // ========
    // Checks
    a_start_busy: assert property (wr_i && addr_i == 5'h11 |=> transfer_busy_o)
        else $error("no busy after start");
    a_walk_length: assert property ($rose(transfer_busy_o) |-> ##15 transfer_busy_o ##1 !transfer_busy_o)
        else $error("walk length wrong");
    a_write_flag: assert property (ctl_rd && transfer_busy_o && dir_r |=> rdata_o[6:5] == 2'b01)
        else $error("write flag wrong");
    a_read_flag: assert property (ctl_rd && transfer_busy_o && !dir_r |=> rdata_o[6:5] == 2'b10)
        else $error("read flag wrong");
    a_idle_flags: assert property (ctl_rd && !transfer_busy_o |=> rdata_o[7:5] == 3'b011)
        else $error("idle flags wrong");
    a_remark_lsb: assert property (wr_i && addr_i == 5'h0b |=> remark_priority_o[0] == $past(wdata_i[7]))
        else $error("remark lsb wrong");
    a_forward_mask: assert property (wr_i && addr_i == 5'h0d |=> forward_port_mask_o == $past(wdata_i[5:0]))
        else $error("forward mask wrong");
    a_mode_decode: assert property (wr_i && addr_i == 5'h01 |=> rule_mode_o == $past(wdata_i[5:4])
        && match_on_equal_o == $past(wdata_i[0])) else $error("mode decode wrong");
    cover property ($fell(transfer_busy_o) && dir_r);
    cover property ($fell(transfer_busy_o) && !dir_r);
    cover property (ctl_rd && transfer_busy_o);
endmodule
bind acl_table_indirect_access acl_table_chk u_chk (.clk_sys_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .remark_priority_o, .forward_port_mask_o, .rule_mode_o, .match_on_equal_o, .transfer_busy_o);

// *** testbench/acl_host_model.sv ***
module acl_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic      [4:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr_o = '0;
        wdata_o = '0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask
    // Result bytes are only trusted once the completion bit is back
    task automatic poll(input int n, output logic [7:0] d);
        repeat (40) begin
            rd(5'h12, d);
            if (d[n] === 1'b1) return;
        end
    endtask
endmodule

// *** testbench/tb_acl_table_indirect_access.sv ***
module tb_acl_table_indirect_access;
    timeunit 1ns;
    timeprecision 1ps;
    import acl_table_pkg::*;
    logic clk_sys_i, reset_i, wr_i, rd_i, match_on_equal_o, transfer_busy_o;
    logic [4:0] addr_i;
    logic [7:0] wdata_i, rdata_o, d;
    logic [2:0] remark_priority_o;
    logic [5:0] forward_port_mask_o;
    rule_mode_t rule_mode_o;
    logic [7:0] stg [16];
    logic [7:0] tbl [16][16];
    logic [31:0] seed = 32'd94765;
    int miscompares = 0;
    int checks_done = 0;
    acl_table_indirect_access DUT (.clk_sys_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .remark_priority_o, .forward_port_mask_o, .rule_mode_o, .match_on_equal_o, .transfer_busy_o);
    acl_host_model host (.clk_i(clk_sys_i), .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i),
        .wr_o(wr_i), .rd_o(rd_i));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Control readback while a walk runs: the flag of the running direction is low
    function automatic logic [7:0] busy_ctl(input logic dir, input logic [3:0] i);
        return {1'b0, ~dir, dir, dir, i};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ========
    // One transfer with fresh staging bytes, so unselected lanes are told apart
    task automatic xfer(input logic dir, input logic [3:0] i, input logic [15:0] sel);
        for (int b = 0; b < 16; b++) begin
            seed = lfsr(seed);
            stg[b] = seed[7:0];
            host.wr(5'(b), stg[b]);
        end
        host.wr(5'h12, {3'b000, dir, i});
        host.wr(5'h10, sel[15:8]);
        host.wr(5'h11, sel[7:0]);
        host.rd(5'h12, d);
        chk(d, busy_ctl(dir, i));
        host.poll(dir ? 6 : 5, d);
        chk(d, {3'b011, dir, i});
        host.rd(5'h10, d);
        chk(d, sel[15:8]);
        host.rd(5'h11, d);
        chk(d, sel[7:0]);
        for (int b = 0; b < 16; b++)
            if (sel[15 - b] && dir) tbl[i][b] = stg[b];
            else if (sel[15 - b]) stg[b] = tbl[i][b];
        for (int b = 0; b < 16 && !dir; b++) begin
            host.rd(5'(b), d);
            chk(d, stg[b]);
        end
        $display("transfer dir %0b entry %0d done", dir, i);
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end
    initial begin
        reset_i = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        host.rd(5'h12, d);
        chk(d, 8'h60);
        host.rd(5'h1f, d);
        chk(d, 8'h00);
        for (int m = 0; m < 4; m++) begin
            host.wr(5'h01, 8'(m * 16 + m % 2));
            #1;
            chk({5'b0, rule_mode_o, match_on_equal_o}, {5'b0, 2'(m), m[0]});
        end
        host.wr(5'h0d, 8'hc1);
        host.wr(5'h0a, 8'h02);
        host.wr(5'h0b, 8'h80);
        #1;
        chk({2'b0, forward_port_mask_o}, 8'h01);
        chk({5'b0, remark_priority_o}, 8'h05);
        $display("field decode test done");
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            xfer(1'b1, 4'(k * 5), 16'hffff);
            xfer(1'b1, 4'(k * 5), seed[23:8]);
            xfer(1'b0, 4'(k * 5), k == 0 ? 16'h8001 : seed[31:16]);
        end
        give_verdict();
    end
endmodule
